/* lsi_led_board.sv */
// Board model of the indicator lamps, timing how long the first lamp holds each level.
module lsi_led_board (
  // Clock.
  input  wire logic        aclk,
  // Lamp drive, high means lit.
  input  wire logic [2:0]  led,
  // Cycles held so far and length of the last finished run.
  output logic      [15:0] run_q,
  output logic      [15:0] last_run_q
);
  timeunit 1ns;
  timeprecision 1ps;

  logic prev_q;

  // A change closes a run; counting from the change gives the blink period.
  always_ff @(posedge aclk) begin
    prev_q <= led[0];
    if (led[0] != prev_q) begin
      last_run_q <= run_q + 16'h0001;
      run_q      <= 16'h0000;
    end else begin
      run_q <= run_q + 16'h0001;
    end
  end
endmodule // lsi_led_board

/* lsi_pkg.sv */
// Shared constants, types and helper functions of the LED status indicator.
package lsi_pkg;

  // Bus and counter geometry.
  localparam int ADDR_W  = 12;
  localparam int CNT_W   = 27;
  localparam int NUM_LED = 3;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] OFF_CFG  = 12'h450;
  localparam logic [ADDR_W-1:0] OFF_STAT = 12'h454;

  // Configuration reset value and writable bits (bit 15 is reserved, reads zero).
  localparam logic [15:0] CFG_RESET   = 16'h2610;
  localparam logic [15:0] CFG_RW_MASK = 16'h7FFF;

  // Status register layout: LED states sit in the low bits.
  localparam int STAT_LED_LSB   = 0;
  localparam int STAT_LOST_BIT  = 3;
  localparam int STAT_PRBS_BIT  = 4;
  localparam int STAT_BLINK_BIT = 5;

  // Clock rate in kilohertz and blink periods in milliseconds.
  localparam int unsigned CLK_KHZ    = 250000;
  localparam int unsigned BLINK_MS_0 = 50;
  localparam int unsigned BLINK_MS_1 = 100;
  localparam int unsigned BLINK_MS_2 = 200;
  localparam int unsigned BLINK_MS_3 = 500;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Per-LED function select codes.
  typedef enum logic [3:0] {
    OPT_LINK      = 4'h0,
    OPT_LINK_ACT  = 4'h1,
    OPT_LINK_TX   = 4'h2,
    OPT_LINK_RX   = 4'h3,
    OPT_MASTER    = 4'h4,
    OPT_SLAVE     = 4'h5,
    OPT_ACT       = 4'h6,
    OPT_RSV7      = 4'h7,
    OPT_RSV8      = 4'h8,
    OPT_LINK_LOST = 4'h9,
    OPT_PRBS_ERR  = 4'hA,
    OPT_MAC_ERR   = 4'hB
  } lsi_opt_t;

  // Layout of the indicator configuration register.
  typedef struct packed {
    logic                       rsv;
    logic                       bypass;
    logic [1:0]                 rate;
    lsi_opt_t [NUM_LED-1:0]     opt;
  } lsi_cfg_t;

  // Condition inputs from the PHY core.
  typedef struct packed {
    logic link_up;
    logic master;
    logic tx_act;
    logic rx_act;
    logic prbs_err;
    logic mac_tx_err;
    logic mac_rx_err;
  } lsi_events_t;

  // Milliseconds to clock cycles.
  function automatic int unsigned ms_to_cyc(input int unsigned ms);
    return ms * CLK_KHZ;
  endfunction

  // Word-aligned address match.
  function automatic logic word_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction

  // Level that one LED shows for its select code; reserved codes stay dark.
  function automatic logic led_select(input lsi_opt_t opt, input logic link, input logic master,
                                      input logic txs, input logic rxs, input logic errs,
                                      input logic lost, input logic prbs, input logic blink);
    logic v;
    v = 1'b0;
    case (opt)
      OPT_LINK:      v = link;
      OPT_LINK_ACT:  v = link & ~((txs | rxs) & blink);
      OPT_LINK_TX:   v = link & ~(txs & blink);
      OPT_LINK_RX:   v = link & ~(rxs & blink);
      OPT_MASTER:    v = link & master;
      OPT_SLAVE:     v = link & ~master;
      OPT_ACT:       v = txs | rxs;
      OPT_LINK_LOST: v = lost;
      OPT_PRBS_ERR:  v = prbs;
      OPT_MAC_ERR:   v = errs;
      default:       v = 1'b0;
    endcase
    return v;
  endfunction

endpackage

/* lsi_stretch.sv */
// Pulse stretcher that holds a short event for one blink period.
module lsi_stretch #(
  parameter int CW = 27
) (
  // Clock and reset.
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Control.
  input  wire logic          bypass,
  input  wire logic [CW-1:0] hold_cyc,
  // Event in and stretched level out.
  input  wire logic          pulse_in,
  output logic               level_out
);

  logic [CW-1:0] cnt_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Reload on every event so that a burst stays lit one period past its last pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (pulse_in) begin
      cnt_q <= hold_cyc;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Bypass passes the raw event, at the cost of invisible single-cycle pulses.
  assign level_out = bypass ? pulse_in : (pulse_in | (cnt_q != '0));

  a_stretch_hold: assert property (
    !bypass && pulse_in && hold_cyc > 2 |=> level_out [*2])
    else $error("Stretched event dropped too early.");
  a_bypass_raw: assert property (bypass |-> level_out == pulse_in)
    else $error("Bypassed event not passed directly.");

endmodule // lsi_stretch

/* lsi_top.sv */
// LED status indicator with AXI4-Lite configuration and status registers.
//
// Our own choice: the AXI4-Lite slave port.
module lsi_top
  import lsi_pkg::*;
#(
  parameter logic [lsi_pkg::CNT_W-1:0] RATE0_CYC =
    lsi_pkg::CNT_W'(lsi_pkg::ms_to_cyc(lsi_pkg::BLINK_MS_0)),
  parameter logic [lsi_pkg::CNT_W-1:0] RATE1_CYC =
    lsi_pkg::CNT_W'(lsi_pkg::ms_to_cyc(lsi_pkg::BLINK_MS_1)),
  parameter logic [lsi_pkg::CNT_W-1:0] RATE2_CYC =
    lsi_pkg::CNT_W'(lsi_pkg::ms_to_cyc(lsi_pkg::BLINK_MS_2)),
  parameter logic [lsi_pkg::CNT_W-1:0] RATE3_CYC =
    lsi_pkg::CNT_W'(lsi_pkg::ms_to_cyc(lsi_pkg::BLINK_MS_3))
) (
  // Clock and reset.
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write address.
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [lsi_pkg::ADDR_W-1:0]    s_axi_awaddr,
  // AXI4-Lite write data.
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  // AXI4-Lite write response.
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  // AXI4-Lite read address.
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [lsi_pkg::ADDR_W-1:0]    s_axi_araddr,
  // AXI4-Lite read data.
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  // PHY conditions and clear strobes.
  input  wire lsi_pkg::lsi_events_t          events,
  input  wire logic                          status_reg_read,
  input  wire logic                          prbs_clear,
  // LED pins, high means lit.
  output logic [lsi_pkg::NUM_LED-1:0]        led
);

  import lsi_pkg::*;

  lsi_cfg_t              cfg_q;
  logic                  aw_have_q;
  logic                  w_have_q;
  logic [ADDR_W-1:0]     awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;
  logic                  do_wr;
  logic [15:0]           cfg_new;
  logic [CNT_W-1:0]      limit_m1;
  logic [CNT_W-1:0]      cnt_q;
  logic                  blink_q;
  logic                  link_prev_q;
  logic                  lost_q;
  logic                  prbs_q;
  logic                  tx_s;
  logic                  rx_s;
  logic                  err_s;
  logic [NUM_LED-1:0]    led_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address and data are taken independently and held until the write is done.
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign do_wr         = aw_have_q && w_have_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_wr) begin
      w_have_q <= 1'b0;
    end
  end

  // Byte-lane merge of the 16-bit configuration word.
  always_comb begin
    cfg_new = cfg_q;
    if (wstrb_q[0]) begin
      cfg_new[7:0] = wdata_q[7:0];
    end
    if (wstrb_q[1]) begin
      cfg_new[15:8] = wdata_q[15:8];
    end
    cfg_new = cfg_new & CFG_RW_MASK;
  end

  // Configuration register; the status word is read-only so writes there are refused.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= lsi_cfg_t'(CFG_RESET);
    end else if (do_wr && word_hit(awaddr_q, OFF_CFG)) begin
      cfg_q <= lsi_cfg_t'(cfg_new);
    end
  end

  // Write response follows the completed write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= word_hit(awaddr_q, OFF_CFG) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;

  // Read data are registered; unmapped addresses answer zero with an error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
      if (word_hit(s_axi_araddr, OFF_CFG)) begin
        rdata_q[15:0] <= cfg_q;
      end else if (word_hit(s_axi_araddr, OFF_STAT)) begin
        rdata_q[STAT_LED_LSB +: NUM_LED] <= led_q;
        rdata_q[STAT_LOST_BIT]           <= lost_q;
        rdata_q[STAT_PRBS_BIT]           <= prbs_q;
        rdata_q[STAT_BLINK_BIT]          <= blink_q;
      end else begin
        rresp_q <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // Blink period in cycles, minus one, for the selected rate.
  always_comb begin
    unique case (cfg_q.rate)
      2'h0: limit_m1 = RATE0_CYC - 1'b1;
      2'h1: limit_m1 = RATE1_CYC - 1'b1;
      2'h2: limit_m1 = RATE2_CYC - 1'b1;
      2'h3: limit_m1 = RATE3_CYC - 1'b1;
    endcase
  end

  // Phase flips once per period; the compare is >= so a rate change never overruns.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q   <= '0;
      blink_q <= 1'b0;
    end else if (cnt_q >= limit_m1) begin
      cnt_q   <= '0;
      blink_q <= ~blink_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Stretchers share the blink period so a brief event shows for one full phase.
  lsi_stretch #(.CW(CNT_W)) u_tx_str (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .bypass    (cfg_q.bypass),
    .hold_cyc  (limit_m1),
    .pulse_in  (events.tx_act),
    .level_out (tx_s)
  );

  lsi_stretch #(.CW(CNT_W)) u_rx_str (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .bypass    (cfg_q.bypass),
    .hold_cyc  (limit_m1),
    .pulse_in  (events.rx_act),
    .level_out (rx_s)
  );

  lsi_stretch #(.CW(CNT_W)) u_err_str (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .bypass    (cfg_q.bypass),
    .hold_cyc  (limit_m1),
    .pulse_in  (events.mac_tx_err | events.mac_rx_err),
    .level_out (err_s)
  );

  // Link-loss latch: a new loss in the clearing cycle wins over the clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_prev_q <= 1'b0;
      lost_q      <= 1'b0;
    end else begin
      link_prev_q <= events.link_up;
      lost_q      <= (link_prev_q & ~events.link_up) | (lost_q & ~status_reg_read);
    end
  end

  // Pattern-error latch, set also wins over clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prbs_q <= 1'b0;
    end else begin
      prbs_q <= events.prbs_err | (prbs_q & ~prbs_clear);
    end
  end

  // LED pins are registered to keep them glitch free.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_q <= '0;
    end else begin
      for (int i = 0; i < NUM_LED; i++) begin
        led_q[i] <= led_select(cfg_q.opt[i], events.link_up, events.master, tx_s, rx_s,
                               err_s, lost_q, prbs_q, blink_q);
      end
    end
  end

  assign led = led_q;

  // The link, master and activity select codes are checked against the conditions sampled one edge earlier.
  a_blink_period: assert property ($changed(blink_q) |-> $past(cnt_q) >= $past(limit_m1))
    else $error("Blink phase changed before the period ended.");
  a_link_ok_led: assert property (
    cfg_q.opt[0] == OPT_LINK |=> led_q[0] == $past(events.link_up))
    else $error("Link LED does not follow link state.");
  a_master_led: assert property (
    cfg_q.opt[1] == OPT_MASTER |=> led_q[1] == $past(events.link_up && events.master))
    else $error("Master LED wrong.");
  a_activity_led: assert property (
    cfg_q.opt[2] == OPT_ACT |=> led_q[2] == $past(tx_s || rx_s))
    else $error("Activity LED wrong.");

  // Both latches must set, hold and clear exactly as their strobes say.
  a_lost_latch: assert property (
    $fell(events.link_up) |=> lost_q [*2] or (lost_q ##1 $past(status_reg_read)))
    else $error("Link loss not latched.");
  a_lost_hold: assert property (lost_q && !status_reg_read |=> lost_q)
    else $error("Link loss cleared without a status read.");
  a_lost_clear: assert property (
    lost_q && status_reg_read && !$fell(events.link_up) |=> !lost_q)
    else $error("Status read did not clear the link-loss latch.");
  a_prbs_latch: assert property (events.prbs_err |=> prbs_q)
    else $error("Pattern error not latched.");
  a_prbs_hold: assert property (prbs_q && !prbs_clear |=> prbs_q)
    else $error("Pattern error cleared without a clear strobe.");
  a_prbs_clear: assert property (
    prbs_q && prbs_clear && !events.prbs_err |=> !prbs_q)
    else $error("Clear strobe did not drop the pattern error.");
  a_mac_err_led: assert property (
    cfg_q.opt[0] == OPT_MAC_ERR |=> led_q[0] == $past(err_s))
    else $error("Interface error LED wrong.");
  a_reserved_dark: assert property (
    cfg_q.opt[1] inside {OPT_RSV7, OPT_RSV8} || cfg_q.opt[1] > OPT_MAC_ERR |=> !led_q[1])
    else $error("Reserved code lit the LED.");
  a_bypass_err: assert property (
    cfg_q.bypass |-> err_s == (events.mac_tx_err || events.mac_rx_err))
    else $error("Bypass did not pass errors directly.");

  c_blink_act: cover property (cfg_q.opt[0] == OPT_LINK_ACT && tx_s && $changed(blink_q));
  c_lost_clear: cover property (lost_q ##1 status_reg_read ##1 !lost_q);
  c_cfg_write: cover property (do_wr && word_hit(awaddr_q, OFF_CFG));
  c_prbs_clear: cover property (prbs_q ##1 prbs_clear ##1 !prbs_q);

endmodule // lsi_top

/* tb_top.sv */
// Self-checking bench of the LED status indicator.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lsi_pkg::*;

  // Blink periods shortened so a full sweep stays brief.
  localparam int RC [4] = '{8, 16, 32, 64};

  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, sr_read, p_clr;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [2:0]  led;
  logic [15:0] run, last_run;
  lsi_events_t ev;
  int          bad_count, total_checks, cyc;

  lsi_top #(
    .RATE0_CYC(27'h08), .RATE1_CYC(27'h10), .RATE2_CYC(27'h20), .RATE3_CYC(27'h40)
  ) lsi_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .events(ev), .status_reg_read(sr_read), .prbs_clear(p_clr), .led(led)
  );

  lsi_led_board lsi_led_board_i (.aclk(aclk), .led(led), .run_q(run), .last_run_q(last_run));

  // Free-running clock.
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cut a hang short; the whole run needs well under a thousand cycles.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Readies are combinational and inputs only move at rising edges, so the falling edge
  // sees what the next rising edge will sample.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ap;
    logic wp;
    logic ta;
    logic tw;
    ap = 1'b1;
    wp = 1'b1;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (ap || wp) begin
      @(negedge aclk);
      ta = awready && ap;
      tw = wready && wp;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'b0;
        ap = 1'b0;
      end
      if (tw) begin
        wvalid <= 1'b0;
        wp = 1'b0;
      end
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic set_cfg(input logic b, input logic [1:0] rt, input logic [3:0] o2,
                         input logic [3:0] o1, input logic [3:0] o0);
    axi_write(OFF_CFG, {17'h0, b, rt, o2, o1, o0}, rs);
    check(32'(rs), 32'(RESP_OKAY));
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic led_is(input logic [2:0] exp);
    @(negedge aclk);
    check(32'(led), 32'(exp));
    @(posedge aclk);
  endtask

  task automatic wait_chg;
    logic v;
    @(negedge aclk);
    v = led[0];
    do @(negedge aclk); while (led[0] === v);
    @(negedge aclk);
  endtask

  task automatic t_regs;
    axi_read(OFF_CFG, rd, rs);
    check(rd, 32'h0000_2610);
    check(32'(rs), 32'(RESP_OKAY));
    axi_write(OFF_CFG, 32'hFFFF_FFFF, rs);
    check(32'(rs), 32'(RESP_OKAY));
    axi_read(OFF_CFG, rd, rs);
    check(rd, 32'h0000_7FFF);
    check(32'(rs), 32'(RESP_OKAY));
    axi_write(OFF_STAT, 32'h0000_0000, rs);
    check(32'(rs), 32'(RESP_SLVERR));
    axi_read(12'h460, rd, rs);
    check(rd, 32'h0000_0000);
    check(32'(rs), 32'(RESP_SLVERR));
  endtask

  task automatic t_role;
    set_cfg(1'b0, 2'h0, OPT_SLAVE, OPT_MASTER, OPT_LINK);
    ev.link_up <= 1'b1;
    ev.master  <= 1'b1;
    wait_cyc(3);
    led_is(3'h3);
    ev.master <= 1'b0;
    wait_cyc(3);
    led_is(3'h5);
    ev.link_up <= 1'b0;
    wait_cyc(3);
    led_is(3'h0);
  endtask

  // Every reserved code stays dark even with every input but prbs_err asserted.
  task automatic t_reserved;
    logic [3:0] rsv [6];
    rsv = '{4'h7, 4'h8, 4'hC, 4'hD, 4'hE, 4'hF};
    ev <= '{link_up: 1'b1, master: 1'b1, tx_act: 1'b1, rx_act: 1'b1, mac_tx_err: 1'b1,
            mac_rx_err: 1'b1, prbs_err: 1'b0};
    foreach (rsv[i]) begin
      set_cfg(1'b1, 2'h0, rsv[i], rsv[i], rsv[i]);
      wait_cyc(3);
      led_is(3'h0);
    end
    ev <= '0;
  endtask

  // Steady transmit activity makes the TX and combined codes blink; the RX code stays lit.
  task automatic t_blink;
    @(posedge aclk);
    ev.link_up <= 1'b1;
    ev.tx_act  <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      set_cfg(1'b0, 2'(r), OPT_LINK_TX, OPT_LINK_RX, OPT_LINK_ACT);
      wait_chg();
      wait_chg();
      check(32'(last_run), 32'(RC[r]));
      check(32'(led[1]), 32'h1);
      check(32'(led[2]), 32'(led[0]));
    end
    ev <= '0;
  endtask

  task automatic t_stretch;
    set_cfg(1'b0, 2'h3, OPT_ACT, OPT_ACT, OPT_MAC_ERR);
    wait_cyc(80);
    ev.tx_act     <= 1'b1;
    ev.mac_rx_err <= 1'b1;
    @(posedge aclk);
    ev <= '0;
    wait_cyc(40);
    led_is(3'h7);
    wait_cyc(50);
    led_is(3'h0);
    set_cfg(1'b1, 2'h3, OPT_ACT, OPT_ACT, OPT_MAC_ERR);
    ev.rx_act     <= 1'b1;
    ev.mac_tx_err <= 1'b1;
    wait_cyc(3);
    led_is(3'h7);
    ev <= '0;
    wait_cyc(3);
    led_is(3'h0);
  endtask

  task automatic t_latch;
    set_cfg(1'b0, 2'h0, OPT_LINK, OPT_PRBS_ERR, OPT_LINK_LOST);
    sr_read <= 1'b1;
    p_clr   <= 1'b1;
    @(posedge aclk);
    sr_read    <= 1'b0;
    p_clr      <= 1'b0;
    ev.link_up <= 1'b1;
    wait_cyc(3);
    led_is(3'h4);
    ev.link_up  <= 1'b0;
    ev.prbs_err <= 1'b1;
    @(posedge aclk);
    ev.prbs_err <= 1'b0;
    wait_cyc(20);
    led_is(3'h3);
    axi_read(OFF_STAT, rd, rs);
    check(rd & 32'h18, 32'h18);
    check(32'(rs), 32'(RESP_OKAY));
    sr_read <= 1'b1;
    @(posedge aclk);
    sr_read <= 1'b0;
    wait_cyc(3);
    led_is(3'h2);
    p_clr <= 1'b1;
    @(posedge aclk);
    p_clr <= 1'b0;
    wait_cyc(3);
    led_is(3'h0);
  endtask

  // Main sequence.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sr_read, p_clr} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    ev  = '0;
    cyc = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    led_is(3'h0);
    t_regs();
    t_role();
    t_reserved();
    t_blink();
    t_stretch();
    t_latch();
    complete_run();
  end
endmodule // tb_top
